// File: common/eeprom_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM instruction block
// Assumes: 64 words of 16 bits, 6-bit addresses, system clock of 40 MHz
// Notes: Programming time is the longest write cycle, rounded down to cycles
package eeprom_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;
	localparam int WORDS = 64;
	localparam int HEAD_LAST = 7;
	localparam int DATA_LAST = 15;
	localparam int EXT_HI = 5;
	localparam int EXT_LO = 4;

	localparam logic [1:0] OP_EXT = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_CLEAR = 2'h3;
	localparam logic [1:0] EXT_DISABLE = 2'h0;
	localparam logic [1:0] EXT_WRITE_ALL_CMD = 2'h1;
	localparam logic [1:0] EXT_ENABLE = 2'h3;

	localparam logic [5:0] ADDR_ZERO = 6'h00;
	localparam logic [5:0] ADDR_ONES = 6'h3f;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam logic [9:0] PROT_PAD = 10'h000;

	localparam int CLK_PERIOD_NS = 25;
	localparam int CS_LOW_TIME_NS = 250;
	localparam int CS_LOW_CYCLES = (CS_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_TIME_NS = 10_000_000;
	localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
	localparam int TIMER_W = 19;
	localparam int CSCNT_W = 4;

	typedef enum logic [2:0] {PH_IDLE, PH_HEAD, PH_DATA, PH_OUT, PH_DONE} phase_type;

	typedef struct packed {
		logic [1:0] op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic pre;
		logic pe;
	} cmd_type;
endpackage

// File: src/serial_eeprom_protect_cmd.sv
// Purpose: Instruction logic of a three-wire serial EEPROM with protect boundary
// Assumes: Host clock idles between frames; chip select low resets the link side, all but the command record
// Notes: Array changes only at the end of a programming cycle; boundary changes at execution
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_protect_cmd #(
	parameter int PROG_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
	input wire logic CLK,
	input wire logic CE,
	input wire logic RST_B,
	input wire logic SERIAL_CLOCK_PIN,
	input wire logic CHIP_SELECT,
	input wire logic SERIAL_IN,
	input wire logic PROGRAM_ENABLE_PIN,
	input wire logic PROTECT_REGISTER_SELECT,
	output logic SERIAL_OUT,
	output logic SERIAL_OUT_OE,
	output logic PROGRAMMING_ENABLED,
	output logic PROTECT_LOCKED,
	output logic BUSY
);

	function automatic logic is_data_cmd(input logic [1:0] op, input logic [5:0] addr,
		input logic pre);
		is_data_cmd = !pre && (op == eeprom_pkg::OP_WRITE ||
			(op == eeprom_pkg::OP_EXT &&
			addr[eeprom_pkg::EXT_HI:eeprom_pkg::EXT_LO] == eeprom_pkg::EXT_WRITE_ALL_CMD));
	endfunction

	// Storage lives on CLK; the link side reads it directly, also during a programming cycle
	logic [eeprom_pkg::DATA_W-1:0] mem [eeprom_pkg::WORDS];
	logic [eeprom_pkg::ADDR_W-1:0] prot;
	logic cleared;
	logic locked;
	logic wen;
	logic prev_protect_enable_cmd;
	logic busy;

	// Link side, on the host's serial clock
	eeprom_pkg::phase_type phase;
	logic [4:0] cnt;
	logic [7:0] head;
	logic [eeprom_pkg::DATA_W-1:0] shifter;
	logic [eeprom_pkg::ADDR_W-1:0] rd_addr;
	logic prot_read;
	logic out_bit;
	logic armed;
	eeprom_pkg::cmd_type cmd;

	wire logic sk_rst_b;
	wire logic [7:0] head_next;
	wire logic [1:0] head_op;
	wire logic [5:0] head_addr;
	wire logic head_end;
	wire logic head_data;
	wire logic out_wrap;

	assign sk_rst_b = RST_B & CHIP_SELECT;
	assign head_next = {head[6:0], SERIAL_IN};
	assign head_op = head_next[7:6];
	assign head_addr = head_next[5:0];
	assign head_end = phase == eeprom_pkg::PH_HEAD && cnt == 5'(eeprom_pkg::HEAD_LAST);
	assign head_data = is_data_cmd(head_op, head_addr, PROTECT_REGISTER_SELECT);
	assign out_wrap = cnt == 5'(eeprom_pkg::DATA_LAST);

	always_ff @(posedge SERIAL_CLOCK_PIN or negedge sk_rst_b) begin
		if (!sk_rst_b) begin
			phase <= eeprom_pkg::PH_IDLE;
			cnt <= 5'h00;
			head <= 8'h00;
			shifter <= 16'h0000;
			rd_addr <= 6'h00;
			prot_read <= 1'b0;
			out_bit <= 1'b0;
		end else begin
			case (phase)
				eeprom_pkg::PH_IDLE: begin
					// Leading zeros before the start bit are ignored
					if (SERIAL_IN) begin
						phase <= eeprom_pkg::PH_HEAD;
						cnt <= 5'h00;
					end
				end
				eeprom_pkg::PH_HEAD: begin
					head <= head_next;
					cnt <= cnt + 5'h01;
					if (head_end) begin
						cnt <= 5'h00;
						if (head_op == eeprom_pkg::OP_READ) begin
							phase <= eeprom_pkg::PH_OUT;
							out_bit <= 1'b0;
							prot_read <= PROTECT_REGISTER_SELECT;
							shifter <= PROTECT_REGISTER_SELECT ? {prot, eeprom_pkg::PROT_PAD} :
								mem[head_addr];
							rd_addr <= head_addr + 6'h01;
						end else if (head_data) begin
							phase <= eeprom_pkg::PH_DATA;
						end else begin
							phase <= eeprom_pkg::PH_DONE;
						end
					end
				end
				eeprom_pkg::PH_DATA: begin
					cnt <= cnt + 5'h01;
					if (out_wrap) begin
						phase <= eeprom_pkg::PH_DONE;
					end
				end
				eeprom_pkg::PH_OUT: begin
					out_bit <= shifter[eeprom_pkg::DATA_W-1];
					cnt <= cnt + 5'h01;
					if (out_wrap) begin
						// Next word follows at once, no dummy bit
						cnt <= 5'h00;
						shifter <= prot_read ? 16'h0000 : mem[rd_addr];
						rd_addr <= rd_addr + 6'h01;
					end else begin
						shifter <= {shifter[eeprom_pkg::DATA_W-2:0], 1'b0};
					end
				end
				eeprom_pkg::PH_DONE: begin
					phase <= eeprom_pkg::PH_DONE;
				end
				default: begin
					phase <= eeprom_pkg::PH_IDLE;
				end
			endcase
		end
	end

	// Command record outlives chip select so CLK can execute it after the fall
	always_ff @(posedge SERIAL_CLOCK_PIN or negedge RST_B) begin
		if (!RST_B) begin
			armed <= 1'b0;
			cmd <= '0;
		end else if (!CHIP_SELECT) begin
			armed <= armed;
		end else if (phase == eeprom_pkg::PH_IDLE) begin
			armed <= 1'b0;
		end else if (head_end) begin
			cmd.op <= head_op;
			cmd.addr <= head_addr;
			cmd.pre <= PROTECT_REGISTER_SELECT;
			cmd.pe <= PROGRAM_ENABLE_PIN;
			armed <= !head_data;
		end else if (phase == eeprom_pkg::PH_DATA) begin
			cmd.data <= {cmd.data[eeprom_pkg::DATA_W-2:0], SERIAL_IN};
			cmd.pe <= cmd.pe & PROGRAM_ENABLE_PIN;
			armed <= out_wrap;
		end else if (phase == eeprom_pkg::PH_DONE && is_data_cmd(cmd.op, cmd.addr, cmd.pre)) begin
			// An extra clock after the data spoils the write
			armed <= 1'b0;
		end
	end

	// System clock side
	logic cs_meta;
	logic cs_sync;
	logic cs_prev;
	logic armed_meta;
	logic armed_sync;
	logic spent;
	logic [eeprom_pkg::CSCNT_W-1:0] cs_low_cnt;
	logic low_ok;
	logic show_status;
	logic [eeprom_pkg::TIMER_W-1:0] timer;
	logic pg_all;
	logic [eeprom_pkg::ADDR_W-1:0] pg_addr;
	logic [eeprom_pkg::DATA_W-1:0] pg_data;

	wire logic cs_fall;
	wire logic take;
	wire logic commit;
	wire logic [1:0] ext;
	wire logic pr_ok;
	wire logic do_wen;
	wire logic do_wds;
	wire logic do_protect_enable_cmd;
	wire logic do_lock;
	wire logic do_clear;
	wire logic do_protect_write_cmd;
	wire logic do_write;
	wire logic do_write_all_cmd;

	assign cs_fall = cs_prev && !cs_sync;
	assign take = CE && cs_fall && armed_sync && !spent && !busy;
	assign commit = CE && busy && timer == '0;
	assign ext = cmd.addr[eeprom_pkg::EXT_HI:eeprom_pkg::EXT_LO];
	assign pr_ok = cmd.pre && cmd.pe && prev_protect_enable_cmd && wen && !locked;
	assign do_wen = cmd.op == eeprom_pkg::OP_EXT && ext == eeprom_pkg::EXT_ENABLE &&
		!cmd.pre && cmd.pe;
	assign do_wds = cmd.op == eeprom_pkg::OP_EXT && ext == eeprom_pkg::EXT_DISABLE && !cmd.pre;
	assign do_protect_enable_cmd = cmd.op == eeprom_pkg::OP_EXT && ext == eeprom_pkg::EXT_ENABLE &&
		cmd.pre && cmd.pe && wen;
	assign do_lock = cmd.op == eeprom_pkg::OP_EXT && cmd.addr == eeprom_pkg::ADDR_ZERO && pr_ok;
	assign do_clear = cmd.op == eeprom_pkg::OP_CLEAR && cmd.addr == eeprom_pkg::ADDR_ONES && pr_ok;
	assign do_protect_write_cmd = cmd.op == eeprom_pkg::OP_WRITE && pr_ok;
	assign do_write = cmd.op == eeprom_pkg::OP_WRITE && !cmd.pre && cmd.pe && wen &&
		(cleared || cmd.addr < prot);
	assign do_write_all_cmd = cmd.op == eeprom_pkg::OP_EXT && ext == eeprom_pkg::EXT_WRITE_ALL_CMD &&
		!cmd.pre && cmd.pe && wen && cleared;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cs_meta <= 1'b0;
			cs_sync <= 1'b0;
			cs_prev <= 1'b0;
			armed_meta <= 1'b0;
			armed_sync <= 1'b0;
			spent <= 1'b0;
		end else if (CE) begin
			cs_meta <= CHIP_SELECT;
			cs_sync <= cs_meta;
			cs_prev <= cs_sync;
			armed_meta <= armed;
			armed_sync <= armed_meta;
			// One execution per loaded frame; a status poll must not replay it
			if (cs_fall && armed_sync) begin
				spent <= 1'b1;
			end else if (!armed_sync) begin
				spent <= 1'b0;
			end
		end
	end

	// Status is shown only once chip select has stayed low long enough
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cs_low_cnt <= '0;
			low_ok <= 1'b0;
		end else if (CE) begin
			if (cs_sync) begin
				cs_low_cnt <= '0;
			end else if (cs_low_cnt != eeprom_pkg::CSCNT_W'(eeprom_pkg::CS_LOW_CYCLES)) begin
				cs_low_cnt <= cs_low_cnt + 1'b1;
			end
			if (cs_fall) begin
				low_ok <= 1'b0;
			end else if (cs_low_cnt == eeprom_pkg::CSCNT_W'(eeprom_pkg::CS_LOW_CYCLES)) begin
				low_ok <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			wen <= 1'b0;
			prev_protect_enable_cmd <= 1'b0;
			prot <= eeprom_pkg::ADDR_ONES;
			cleared <= 1'b1;
			locked <= 1'b0;
			busy <= 1'b0;
			show_status <= 1'b0;
			timer <= '0;
			pg_all <= 1'b0;
			pg_addr <= '0;
			pg_data <= '0;
		end else if (CE) begin
			if (take) begin
				prev_protect_enable_cmd <= do_protect_enable_cmd;
				if (do_wen) begin
					wen <= 1'b1;
				end else if (do_wds) begin
					wen <= 1'b0;
				end
				if (do_clear) begin
					prot <= eeprom_pkg::ADDR_ONES;
					cleared <= 1'b1;
				end else if (do_protect_write_cmd) begin
					prot <= cmd.addr;
					cleared <= 1'b0;
				end
				if (do_lock) begin
					locked <= 1'b1;
				end
				show_status <= do_write || do_write_all_cmd;
				if (do_write || do_write_all_cmd) begin
					busy <= 1'b1;
					timer <= eeprom_pkg::TIMER_W'(PROG_CYCLES - 1);
					pg_all <= do_write_all_cmd;
					pg_addr <= cmd.addr;
					pg_data <= cmd.data;
				end
			end else if (cs_fall && !busy) begin
				show_status <= 1'b0;
			end
			if (busy) begin
				if (timer == '0) begin
					busy <= 1'b0;
				end else begin
					timer <= timer - 1'b1;
				end
			end
		end
	end

	// Written at the end of the cycle so a read before ready sees old data
	for (genvar i = 0; i < eeprom_pkg::WORDS; i++) begin : g_word
		always_ff @(posedge CLK or negedge RST_B) begin
			if (!RST_B) begin
				mem[i] <= eeprom_pkg::ERASED_WORD;
			end else if (commit && (pg_all || pg_addr == eeprom_pkg::ADDR_W'(i))) begin
				mem[i] <= pg_data;
			end
		end
	end

	assign SERIAL_OUT = phase == eeprom_pkg::PH_OUT ? out_bit : !busy;
	assign SERIAL_OUT_OE = cs_sync && (phase == eeprom_pkg::PH_OUT ||
		(show_status && low_ok && phase == eeprom_pkg::PH_IDLE));
	assign PROGRAMMING_ENABLED = wen;
	assign PROTECT_LOCKED = locked;
	assign BUSY = busy;

	busy_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
		$rose(busy) |-> busy [*8])
		else $error("programming cycle ended too early");

	write_start_a: assert property (@(posedge CLK) disable iff (!RST_B)
		take && do_write |=> busy && pg_addr == $past(cmd.addr))
		else $error("write did not start programming");

	wen_needed_a: assert property (@(posedge CLK) disable iff (!RST_B)
		take && !wen && !do_wen |=> !busy && !wen)
		else $error("programming ran while disabled");

	wds_clear_a: assert property (@(posedge CLK) disable iff (!RST_B)
		take && do_wds |=> !PROGRAMMING_ENABLED)
		else $error("write disable did not take effect");

	write_all_cmd_block_a: assert property (@(posedge CLK) disable iff (!RST_B)
		take && cmd.op == eeprom_pkg::OP_EXT && ext == eeprom_pkg::EXT_WRITE_ALL_CMD &&
		!cleared |=> !busy)
		else $error("write-all ran with protection set");

	boundary_store_a: assert property (@(posedge CLK) disable iff (!RST_B)
		take && do_protect_write_cmd |=> prot == $past(cmd.addr) && !cleared)
		else $error("boundary not stored");

	protect_write_a: assert property (@(posedge CLK) disable iff (!RST_B)
		take && !cleared && !cmd.pre && cmd.op == eeprom_pkg::OP_WRITE &&
		cmd.addr >= prot |=> !busy)
		else $error("write to protected word accepted");

	lock_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
		locked |=> locked && $stable(prot) && $stable(cleared))
		else $error("locked protect register changed");

	protect_enable_cmd_chain_a: assert property (@(posedge CLK) disable iff (!RST_B)
		take && !prev_protect_enable_cmd |=> $stable(cleared) && $stable(prot))
		else $error("clear ran without protect enable");

	status_out_a: assert property (@(posedge CLK) disable iff (!RST_B)
		SERIAL_OUT_OE && phase != eeprom_pkg::PH_OUT |-> SERIAL_OUT == !busy)
		else $error("status bit wrong");

	dummy_bit_a: assert property (@(posedge SERIAL_CLOCK_PIN) disable iff (!sk_rst_b)
		head_end && head_op == eeprom_pkg::OP_READ |=> phase == eeprom_pkg::PH_OUT && !out_bit)
		else $error("dummy bit missing");

endmodule

`default_nettype wire

// File: tb/eeprom_host.sv
// Purpose: Host side of the serial link, sending frames and collecting read bits
// Assumes: Serial clock stands still low outside frames, 6 ns period inside them
// Notes: Lines the host lets go are driven to the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module eeprom_host (
	output logic sk,
	output logic cs,
	output logic si,
	output logic pe,
	output logic pre,
	input wire logic so
);
	logic [63:0] rd;
	initial begin
		sk = 1'h0;
		cs = 1'h0;
		si = 1'h0;
		pe = 1'h0;
		pre = 1'h0;
		rd = '0;
	end
	// Bits go out MSB first, changed while the clock is low
	task automatic frame(input logic [31:0] b, input int n, input logic pe_v, input logic pre_v,
		input int nr);
		rd = '0;
		cs = 1'h1;
		pe = pe_v;
		pre = pre_v;
		#10;
		for (int i = n - 1; i >= -nr; i--) begin
			si = (i >= 0) ? b[i] : ~si;
			#3 sk = 1'h1;
			#1;
			if (i <= 0) begin
				rd = {rd[62:0], so};
			end
			#2 sk = 1'h0;
		end
		// Falls before any further clock edge, then waits out the low time
		cs = 1'h0;
		si = ~si;
		pe = ~pe_v;
		pre = ~pre_v;
		#300;
	endtask
	// Chip select alone, for polling the ready/busy status
	task automatic set_cs(input logic v);
		cs = v;
	endtask
endmodule
`default_nettype wire

// File: tb/test_serial_eeprom_protect_cmd.sv
// Purpose: Self-checking bench for the serial EEPROM instruction block
// Assumes: Programming time shortened to 20 cycles
// Notes: Host frames come from the partner model; bench checks ports
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_protect_cmd;
	localparam int PC = 20;
	logic CLK, RST_B, CE, sk, cs, si, pe, pre, so, so_oe, wen, lock, busy;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	eeprom_host host (.sk(sk), .cs(cs), .si(si), .pe(pe), .pre(pre), .so(so));
	serial_eeprom_protect_cmd #(.PROG_CYCLES(PC)) dut (.CLK(CLK), .CE(CE), .RST_B(RST_B),
		.SERIAL_CLOCK_PIN(sk), .CHIP_SELECT(cs), .SERIAL_IN(si), .PROGRAM_ENABLE_PIN(pe),
		.PROTECT_REGISTER_SELECT(pre), .SERIAL_OUT(so), .SERIAL_OUT_OE(so_oe),
		.PROGRAMMING_ENABLED(wen), .PROTECT_LOCKED(lock), .BUSY(busy));
	initial begin
		CLK = 1'h0;
		forever #12.5 CLK = ~CLK;
	end
	task automatic stop_test;
		if (error_cnt == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Generous ceiling: the whole run needs under a thousand cycles
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 8000) begin
			error_cnt++;
			stop_test;
		end
	end
	task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [8:0] ins(input logic [1:0] op, input logic [5:0] a);
		return {1'h1, op, a};
	endfunction
	// One programming frame, then the status shown on the output while busy
	task automatic run(input logic [31:0] b, input int n, input logic pe_v, input logic pre_v,
		input logic go);
		host.frame(b, n, pe_v, pre_v, 0);
		chk("busy", busy, go);
		if (go) begin
			host.set_cs(1'h1);
			repeat (3) @(negedge CLK);
			chk("status busy", {so_oe, so}, 2'h2);
			for (int k = 0; k < 40 && busy !== 1'h0; k++) @(negedge CLK);
			chk("busy end", busy, 1'h0);
			repeat (3) @(negedge CLK);
			chk("status ready", {so_oe, so}, 2'h3);
			host.set_cs(1'h0);
			#300;
		end
	endtask
	task automatic rd_word(input logic [5:0] a, input logic [15:0] exp);
		host.frame(ins(eeprom_pkg::OP_READ, a), 9, 1'h0, 1'h0, 16);
		chk("read word", host.rd[16:0], {1'h0, exp});
	endtask
	task automatic pr_read(input logic [5:0] exp);
		host.frame(ins(eeprom_pkg::OP_READ, 6'h00), 9, 1'h0, 1'h1, 6);
		chk("boundary", host.rd[6:0], {1'h0, exp});
	endtask
	task automatic pr_en;
		host.frame(ins(eeprom_pkg::OP_EXT, 6'h30), 9, 1'h1, 1'h1, 0);
	endtask
	task automatic t_refuse;
		run({ins(eeprom_pkg::OP_WRITE, 6'h03), 16'h1234}, 25, 1'h1, 1'h0, 1'h0);
		rd_word(6'h03, eeprom_pkg::ERASED_WORD);
	endtask
	task automatic t_write;
		run(ins(eeprom_pkg::OP_EXT, 6'h30), 9, 1'h1, 1'h0, 1'h0);
		chk("enabled", wen, 1'h1);
		run({ins(eeprom_pkg::OP_WRITE, 6'h05), 16'ha5c3}, 25, 1'h1, 1'h0, 1'h1);
		run({ins(eeprom_pkg::OP_WRITE, 6'h06), 16'h1e0f}, 25, 1'h0, 1'h0, 1'h0);
		run({ins(eeprom_pkg::OP_WRITE, 6'h06), 16'h1e0f}, 25, 1'h1, 1'h0, 1'h1);
		host.frame(ins(eeprom_pkg::OP_READ, 6'h05), 9, 1'h0, 1'h0, 32);
		chk("stream", host.rd[32:0], {1'h0, 16'ha5c3, 16'h1e0f});
	endtask
	task automatic t_write_all_cmd;
		run({ins(eeprom_pkg::OP_EXT, 6'h10), 16'h5aa5}, 25, 1'h1, 1'h0, 1'h1);
		rd_word(6'h3f, 16'h5aa5);
		rd_word(6'h00, 16'h5aa5);
	endtask
	task automatic t_protect;
		pr_en;
		run(ins(eeprom_pkg::OP_WRITE, 6'h20), 9, 1'h1, 1'h1, 1'h0);
		pr_read(6'h20);
		run({ins(eeprom_pkg::OP_WRITE, 6'h20), 16'h0001}, 25, 1'h1, 1'h0, 1'h0);
		run({ins(eeprom_pkg::OP_WRITE, 6'h1f), 16'h0002}, 25, 1'h1, 1'h0, 1'h1);
		run({ins(eeprom_pkg::OP_EXT, 6'h10), 16'h0003}, 25, 1'h1, 1'h0, 1'h0);
		run(ins(eeprom_pkg::OP_WRITE, 6'h10), 9, 1'h1, 1'h1, 1'h0);
		pr_read(6'h20);
		pr_en;
		run(ins(eeprom_pkg::OP_CLEAR, 6'h3f), 9, 1'h1, 1'h1, 1'h0);
		pr_read(6'h3f);
		run({ins(eeprom_pkg::OP_WRITE, 6'h3f), 16'h0004}, 25, 1'h1, 1'h0, 1'h1);
		pr_en;
		run(ins(eeprom_pkg::OP_WRITE, 6'h3f), 9, 1'h1, 1'h1, 1'h0);
		run({ins(eeprom_pkg::OP_WRITE, 6'h3f), 16'h0005}, 25, 1'h1, 1'h0, 1'h0);
		run({ins(eeprom_pkg::OP_EXT, 6'h10), 16'h0006}, 25, 1'h1, 1'h0, 1'h0);
		rd_word(6'h3f, 16'h0004);
		pr_en;
		run(ins(eeprom_pkg::OP_EXT, 6'h00), 9, 1'h1, 1'h1, 1'h0);
		chk("locked", lock, 1'h1);
		pr_en;
		run(ins(eeprom_pkg::OP_CLEAR, 6'h3f), 9, 1'h1, 1'h1, 1'h0);
		pr_read(6'h3f);
		run(ins(eeprom_pkg::OP_EXT, 6'h00), 9, 1'h1, 1'h0, 1'h0);
		chk("enabled", wen, 1'h0);
		run({ins(eeprom_pkg::OP_WRITE, 6'h05), 16'h0007}, 25, 1'h1, 1'h0, 1'h0);
	endtask
	initial begin
		CE = 1'h1;
		RST_B = 1'h0;
		repeat (8) @(negedge CLK);
		chk("reset state", {so_oe, wen, lock, busy}, 4'h0);
		RST_B = 1'h1;
		repeat (4) @(negedge CLK);
		t_refuse;
		t_write;
		t_write_all_cmd;
		t_protect;
		stop_test;
	end
endmodule
`default_nettype wire
